// >>> core/tcpm_pkg.sv
// constants, types and state layout of the channel pair mode control block
// assumes a single 200 MHz kernel clock; counter and update logic live outside
// What this block does
// - direction field chooses compare output or capture input; other bits change meaning
// - clear bit set forces reference low while filtered external trigger is high
// - mode 000 keeps reference unchanged on counter matches
// - mode 001 drives reference high on counter match
// - mode 010 drives reference low on counter match
// - mode 011 toggles reference on each counter match
// - mode 100 holds reference low always
// - mode 101 holds reference high except while the clear bit and external trigger force it low
// - mode 110 counting up: inactive when counter exceeds compare, else active
// - reference is active high; pin levels follow the polarity bits
// - lock level 3 with output direction ignores mode and preload writes
// - preload set: compare access hits preload copy, moved to shadow on update
// - preload clear: compare writes take effect at once
// - fast bit set: trigger edge acts as match, output changes after 3 cycles
// - fast bit clear: normal comparison, reference follows a match 1 cycle later; fast only in PWM
// - direction 00 out, 01 own input, 10 neighbour input, 11 internal trigger
// - direction field writable only while channel enable is 0
// - filter changes output after N equal samples; code 0000 means no filter
// - filter code 0001 samples at kernel clock with N=2
// - capture divider codes 00,01,10,11 capture every 1st,2nd,4th,8th edge
// - capture edge count is reset while channel enable is 0
package tcpm_pkg;

  // register offsets
  localparam logic [7:0] MODE_CTL_OFS = 8'h18;
  localparam logic [7:0] CHAN_EN_OFS  = 8'h20;
  localparam logic [7:0] CMP1_OFS     = 8'h34;
  localparam logic [7:0] CMP2_OFS     = 8'h38;
  localparam logic [7:0] AUX_CTL_OFS  = 8'h40;

  // reset values
  localparam logic [15:0] MODE_CTL_RST = 16'h0000;
  localparam logic [15:0] CHAN_EN_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST      = 16'h0000;
  localparam logic [3:0]  AUX_CTL_RST  = 4'h0;

  // mode control fields, channel 2 sits one stride above channel 1
  localparam int CH_STRIDE = 8;
  localparam int DIR_POS   = 0;
  localparam int PSC_POS   = 2;
  localparam int FLT_POS   = 4;
  localparam int FAST_POS  = 2;
  localparam int PRE_POS   = 3;
  localparam int MODE_POS  = 4;
  localparam int CLR_POS   = 7;

  // channel enable register fields
  localparam int EN_STRIDE = 4;
  localparam int EN_POS    = 0;
  localparam int POL_POS   = 1;
  localparam int NPOL_POS  = 3;

  // auxiliary control fields
  localparam int LOCK_POS  = 0;
  localparam int OPM_POS   = 2;
  localparam int TSI_POS   = 3;
  localparam logic [1:0] LOCK_FULL = 2'h3;

  // cycle counts and sample divider width
  localparam int FAST_DELAY       = 3;
  localparam int NORMAL_MIN_DELAY = 5;
  localparam int DIV_W            = 5;

  typedef enum logic [2:0] {
    OM_FROZEN  = 3'b000,
    OM_SET     = 3'b001,
    OM_CLEAR   = 3'b010,
    OM_TOGGLE  = 3'b011,
    OM_FORCE_L = 3'b100,
    OM_FORCE_H = 3'b101,
    OM_PWM1    = 3'b110,
    OM_PWM2    = 3'b111
  } tcpm_omode_t;

  typedef enum logic [1:0] {
    DIR_OUT = 2'b00,
    DIR_OWN = 2'b01,
    DIR_NBR = 2'b10,
    DIR_TRC = 2'b11
  } tcpm_dir_t;

  // whole block state
  typedef struct packed {
    logic [15:0]                  mode_ctl;
    logic [15:0]                  chan_en;
    logic [3:0]                   aux;
    logic [1:0][15:0]             cmp_pre;
    logic [1:0][15:0]             cmp_act;
    logic [1:0]                   ref_raw;
    logic [1:0]                   fast_hold;
    logic [1:0][FAST_DELAY-2:0]   fast_pipe;
    logic [DIV_W-1:0]             dts_div;
    logic [1:0][2:0]              flt_cnt;
    logic [1:0]                   ti_filt;
    logic [1:0]                   sel_prev;
    logic [1:0][2:0]              psc_cnt;
    logic [1:0]                   cap_pulse;
    logic [1:0]                   ref_out;
    logic [1:0]                   main_out;
    logic [1:0]                   compl_out;
    logic [15:0]                  rdata;
  } tcpm_st_t;

endpackage

// >>> core/tcpm_top.sv
// channel pair mode control: compare reference, filters and capture divider
// assumes counter value, direction, update and trigger edges come from the timer core
`timescale 1ns/1ps
module tcpm_top
  import tcpm_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  // register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [15:0] REG_RDATA_O,
  // timer core
  input  wire logic [15:0] CNT_I,
  input  wire logic        CNT_DOWN_I,
  input  wire logic        UPDATE_I,
  input  wire logic        TRIG_EDGE_I,
  // pins and internal sources
  input  wire logic        FILTERED_EXTERNAL_TRIGGER_I,
  input  wire logic        TIMER_INPUT_ONE_I,
  input  wire logic        TIMER_INPUT_TWO_I,
  input  wire logic        INTERNAL_TRIGGER_CAPTURE_SRC_I,
  // channel results
  output logic      [1:0]  COMPARE_REFERENCE_O,
  output logic      [1:0]  MAIN_OUT_O,
  output logic      [1:0]  COMPLEMENTARY_OUT_O,
  output logic      [1:0]  CAPTURE_O
);

  // filter setting: log2 of sample divider and sample count N
  function automatic logic [6:0] flt_cfg(input logic [3:0] code);
    case (code)
      4'h0:    flt_cfg = {3'd0, 4'd1};
      4'h1:    flt_cfg = {3'd0, 4'd2};
      4'h2:    flt_cfg = {3'd0, 4'd4};
      4'h3:    flt_cfg = {3'd0, 4'd8};
      4'h4:    flt_cfg = {3'd1, 4'd6};
      4'h5:    flt_cfg = {3'd1, 4'd8};
      4'h6:    flt_cfg = {3'd2, 4'd6};
      4'h7:    flt_cfg = {3'd2, 4'd8};
      4'h8:    flt_cfg = {3'd3, 4'd6};
      4'h9:    flt_cfg = {3'd3, 4'd8};
      4'ha:    flt_cfg = {3'd4, 4'd5};
      4'hb:    flt_cfg = {3'd4, 4'd6};
      4'hc:    flt_cfg = {3'd4, 4'd8};
      4'hd:    flt_cfg = {3'd5, 4'd5};
      4'he:    flt_cfg = {3'd5, 4'd6};
      default: flt_cfg = {3'd5, 4'd8};
    endcase
  endfunction

  // capture divider: number of edges per capture
  function automatic logic [3:0] psc_edges(input logic [1:0] code);
    psc_edges = 4'd1 << code;
  endfunction

  // one channel byte of the mode control register
  function automatic logic [7:0] ch_byte(input logic [15:0] r, input int ch);
    ch_byte = r[ch*CH_STRIDE +: CH_STRIDE];
  endfunction

  tcpm_st_t q;
  tcpm_st_t d;

  // next state
  always_comb begin
    logic [7:0]  cur;
    logic [7:0]  nb;
    logic [1:0]  ti;
    logic [6:0]  cfg;
    logic        tick;
    logic [2:0]  lg;
    logic [3:0]  n;
    logic        en;
    logic        pol;
    logic        npol;
    logic        sel;
    logic        edge_seen;
    logic        match;
    logic        gt;
    logic        pwm1_lvl;
    logic        clr;
    tcpm_omode_t om;
    tcpm_dir_t   dir;
    cur       = '0;
    nb        = '0;
    ti        = {TIMER_INPUT_TWO_I, TIMER_INPUT_ONE_I};
    cfg       = '0;
    tick      = 1'b0;
    lg        = '0;
    n         = '0;
    en        = 1'b0;
    pol       = 1'b0;
    npol      = 1'b0;
    sel       = 1'b0;
    edge_seen = 1'b0;
    match     = 1'b0;
    gt        = 1'b0;
    pwm1_lvl  = 1'b0;
    clr       = 1'b0;
    om        = OM_FROZEN;
    dir       = DIR_OUT;
    d         = q;
    d.dts_div = q.dts_div + 5'h01;
    d.rdata   = '0;

    // register reads, data valid the cycle after the strobe
    if (REG_RD_I) begin
      if (REG_ADDR_I == MODE_CTL_OFS) begin
        d.rdata = q.mode_ctl;
      end else if (REG_ADDR_I == CHAN_EN_OFS) begin
        d.rdata = q.chan_en;
      end else if (REG_ADDR_I == CMP1_OFS) begin
        d.rdata = q.cmp_pre[0];
      end else if (REG_ADDR_I == CMP2_OFS) begin
        d.rdata = q.cmp_pre[1];
      end else if (REG_ADDR_I == AUX_CTL_OFS) begin
        d.rdata = {12'h000, q.aux};
      end else begin
        d.rdata = '0;
      end
    end

    // register writes
    if (REG_WR_I) begin
      if (REG_ADDR_I == MODE_CTL_OFS) begin
        for (int c = 0; c < 2; c++) begin
          cur = ch_byte(q.mode_ctl, c);
          nb  = REG_WDATA_I[c*CH_STRIDE +: CH_STRIDE];
          if (q.chan_en[c*EN_STRIDE + EN_POS]) begin
            nb[DIR_POS +: 2] = cur[DIR_POS +: 2];
          end
          if (q.aux[LOCK_POS +: 2] == LOCK_FULL && cur[DIR_POS +: 2] == DIR_OUT) begin
            nb[MODE_POS +: 3] = cur[MODE_POS +: 3];
            nb[PRE_POS]       = cur[PRE_POS];
          end
          d.mode_ctl[c*CH_STRIDE +: CH_STRIDE] = nb;
        end
      end else if (REG_ADDR_I == CHAN_EN_OFS) begin
        d.chan_en = REG_WDATA_I;
      end else if (REG_ADDR_I == CMP1_OFS || REG_ADDR_I == CMP2_OFS) begin
        for (int c = 0; c < 2; c++) begin
          if (REG_ADDR_I == ((c == 0) ? CMP1_OFS : CMP2_OFS)) begin
            d.cmp_pre[c] = REG_WDATA_I;
            if (!q.mode_ctl[c*CH_STRIDE + PRE_POS]) begin
              d.cmp_act[c] = REG_WDATA_I;
            end
          end
        end
      end else if (REG_ADDR_I == AUX_CTL_OFS) begin
        d.aux = REG_WDATA_I[3:0];
      end
    end

    // input filters, one per timer input, set by that input's channel
    for (int c = 0; c < 2; c++) begin
      cur  = ch_byte(q.mode_ctl, c);
      cfg  = flt_cfg(cur[FLT_POS +: 4]);
      lg   = cfg[6:4];
      n    = cfg[3:0];
      tick = ((q.dts_div & ((5'h01 << lg) - 5'h01)) == ((5'h01 << lg) - 5'h01));
      if (tick) begin
        if (ti[c] == q.ti_filt[c]) begin
          d.flt_cnt[c] = '0;
        end else if ({1'b0, q.flt_cnt[c]} + 4'h1 >= n) begin
          d.ti_filt[c] = ti[c];
          d.flt_cnt[c] = '0;
        end else begin
          d.flt_cnt[c] = q.flt_cnt[c] + 3'h1;
        end
      end
    end

    // per channel compare and capture
    for (int c = 0; c < 2; c++) begin
      cur  = ch_byte(q.mode_ctl, c);
      dir  = tcpm_dir_t'(cur[DIR_POS +: 2]);
      om   = tcpm_omode_t'(cur[MODE_POS +: 3]);
      en   = q.chan_en[c*EN_STRIDE + EN_POS];
      pol  = q.chan_en[c*EN_STRIDE + POL_POS];
      npol = q.chan_en[c*EN_STRIDE + NPOL_POS];
      d.cap_pulse[c] = 1'b0;

      // shadow load on update
      if (UPDATE_I && cur[PRE_POS]) begin
        d.cmp_act[c] = d.cmp_pre[c];
      end

      // input selection
      case (dir)
        DIR_OWN: sel = q.ti_filt[c];
        DIR_NBR: sel = q.ti_filt[1-c];
        DIR_TRC: sel = INTERNAL_TRIGGER_CAPTURE_SRC_I & q.aux[TSI_POS];
        default: sel = 1'b0;
      endcase
      sel = sel ^ pol; // polarity picks the capture edge
      edge_seen = sel & ~q.sel_prev[c];
      d.sel_prev[c] = sel;

      // capture divider
      if (!en || dir == DIR_OUT) begin
        d.psc_cnt[c] = '0;
      end else if (edge_seen) begin
        if ({1'b0, q.psc_cnt[c]} + 4'h1 >= psc_edges(cur[PSC_POS +: 2])) begin
          d.psc_cnt[c]   = '0;
          d.cap_pulse[c] = 1'b1;
          d.cmp_pre[c]   = CNT_I;
          d.cmp_act[c]   = CNT_I;
        end else begin
          d.psc_cnt[c] = q.psc_cnt[c] + 3'h1;
        end
      end

      // compare reference, only in output direction
      match    = (CNT_I == q.cmp_act[c]);
      gt       = (CNT_I > q.cmp_act[c]);
      pwm1_lvl = CNT_DOWN_I ? gt : ~gt;
      d.fast_pipe[c] = {q.fast_pipe[c][FAST_DELAY-3:0], TRIG_EDGE_I};
      if (FAST_DELAY < 3) begin
        d.fast_pipe[c] = '0;
      end
      if (dir == DIR_OUT) begin
        case (om)
          OM_FROZEN:  d.ref_raw[c] = q.ref_raw[c];
          OM_SET:     d.ref_raw[c] = match ? 1'b1 : q.ref_raw[c];
          OM_CLEAR:   d.ref_raw[c] = match ? 1'b0 : q.ref_raw[c];
          OM_TOGGLE:  d.ref_raw[c] = match ? ~q.ref_raw[c] : q.ref_raw[c];
          OM_FORCE_L: d.ref_raw[c] = 1'b0;
          OM_FORCE_H: d.ref_raw[c] = 1'b1;
          OM_PWM1:    d.ref_raw[c] = pwm1_lvl;
          default:    d.ref_raw[c] = ~pwm1_lvl;
        endcase
        // fast response holds the match level until the next real match
        if ((om == OM_PWM1 || om == OM_PWM2) && cur[FAST_POS]) begin
          if (q.fast_pipe[c][FAST_DELAY-2]) begin
            d.fast_hold[c] = 1'b1;
          end else if (match) begin
            d.fast_hold[c] = 1'b0;
          end
          if (d.fast_hold[c]) begin
            d.ref_raw[c] = (om == OM_PWM1);
          end
        end else begin
          d.fast_hold[c] = 1'b0;
        end
      end else begin
        d.ref_raw[c]   = 1'b0;
        d.fast_hold[c] = 1'b0;
      end

      // clear on external trigger, then pin polarity
      clr = cur[CLR_POS] & FILTERED_EXTERNAL_TRIGGER_I & (dir == DIR_OUT);
      d.ref_out[c]   = d.ref_raw[c] & ~clr;
      d.main_out[c]  = d.ref_out[c] ^ pol;
      d.compl_out[c] = ~d.ref_out[c] ^ npol;
    end
  end

  // state register
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q          <= '0;
      q.mode_ctl <= MODE_CTL_RST;
      q.chan_en  <= CHAN_EN_RST;
      q.aux      <= AUX_CTL_RST;
      q.cmp_pre  <= {CMP_RST, CMP_RST};
      q.cmp_act  <= {CMP_RST, CMP_RST};
      q.compl_out <= 2'b11;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state
  assign REG_RDATA_O         = q.rdata;
  assign COMPARE_REFERENCE_O = q.ref_out;
  assign MAIN_OUT_O          = q.main_out;
  assign COMPLEMENTARY_OUT_O = q.compl_out;
  assign CAPTURE_O           = q.cap_pulse;

endmodule

// >>> tb/tcpm_asserts.sv
// port checker for the channel pair mode control block, channel one plus the channel two capture pulse
// assumes only the bench writes the mode and auxiliary registers
`timescale 1ns/1ps
module tcpm_asserts
  import tcpm_pkg::*;
(
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        SYS_RST_I,
  // register port
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  // trigger and results
  input wire logic        FILTERED_EXTERNAL_TRIGGER_I,
  input wire logic [1:0]  COMPARE_REFERENCE_O,
  input wire logic [1:0]  CAPTURE_O
);
  logic [15:0] m_q;
  logic [15:0] mode_nx;
  logic        en0_q;
  logic [1:0]  lk_q;
  logic [2:0]  md;
  logic        dir0;
  logic        oc;
  logic        rf;

  // channel one write filter: direction kept while enabled, mode kept when locked
  always_comb begin
    mode_nx = REG_WDATA_I;
    if (en0_q) begin
      mode_nx[DIR_POS +: 2] = m_q[DIR_POS +: 2];
    end
    if (lk_q == LOCK_FULL && m_q[DIR_POS +: 2] == 2'h0) begin
      mode_nx[MODE_POS +: 3] = m_q[MODE_POS +: 3];
      mode_nx[PRE_POS]       = m_q[PRE_POS];
    end
  end

  // mirror of mode register, channel one enable and lock level
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      m_q   <= MODE_CTL_RST;
      en0_q <= 1'b0;
      lk_q  <= 2'h0;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == MODE_CTL_OFS) m_q <= mode_nx;
      if (REG_ADDR_I == CHAN_EN_OFS) en0_q <= REG_WDATA_I[EN_POS];
      if (REG_ADDR_I == AUX_CTL_OFS) lk_q <= REG_WDATA_I[1:0];
    end
  end

  // decoded channel one view
  assign md   = m_q[MODE_POS+2:MODE_POS];
  assign dir0 = m_q[DIR_POS+1:DIR_POS] == 2'h0;
  assign oc   = dir0 && !m_q[CLR_POS];
  assign rf   = COMPARE_REFERENCE_O[0];

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 16'h0)
    else $error("read data not zero outside read");
  a_cap_one: assert property (CAPTURE_O[0] |=> !CAPTURE_O[0])
    else $error("capture one too long");
  a_cap_two: assert property (CAPTURE_O[1] |=> !CAPTURE_O[1])
    else $error("capture two too long");
  a_frozen_ref: assert property (md == 3'h0 && oc |=> $stable(rf))
    else $error("frozen reference moved");
  a_set_holds: assert property (md == 3'h1 && oc && rf |=> rf)
    else $error("set mode dropped reference");
  a_clear_holds: assert property (md == 3'h2 && oc && !rf |=> !rf)
    else $error("clear mode raised reference");
  a_force_low: assert property (md == 3'h4 && dir0 |=> !rf)
    else $error("forced low reference high");
  a_force_high: assert property (md == 3'h5 && oc |=> rf)
    else $error("forced high reference low");
  a_ext_clear: assert property (dir0 && m_q[CLR_POS] && FILTERED_EXTERNAL_TRIGGER_I |=> !rf)
    else $error("reference not cleared by trigger");
  a_input_ref: assert property (!dir0 |=> !rf)
    else $error("reference active in input direction");

  // main scenarios reached
  cover property (CAPTURE_O[0]);
  cover property (CAPTURE_O[1]);
  cover property (m_q[CLR_POS] && FILTERED_EXTERNAL_TRIGGER_I);
endmodule

bind tcpm_top tcpm_asserts u_tcpm_asserts (
  .MCLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
  .REG_RDATA_O, .FILTERED_EXTERNAL_TRIGGER_I, .COMPARE_REFERENCE_O, .CAPTURE_O
);

// >>> tb/tcpm_pins.sv
// model of the timer pins facing the channel pair
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
module tcpm_pins (
  // clock
  input  wire logic mclk_i,
  // pin levels
  output logic      ti_one_o,
  output logic      ti_two_o,
  output logic      etr_o,
  output logic      trc_o
);
  // all lines idle low
  initial begin
    ti_one_o = 1'b0;
    ti_two_o = 1'b0;
    etr_o    = 1'b0;
    trc_o    = 1'b0;
  end

  // n pulses w cycles high, three low between
  task automatic pulses(input bit two, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      if (two) ti_two_o <= 1'b1;
      else ti_one_o <= 1'b1;
      repeat (w) @(posedge mclk_i);
      ti_one_o <= 1'b0;
      ti_two_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
  endtask

  // external trigger level
  task automatic set_etr(input logic v);
    etr_o <= v;
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the channel pair mode control block
// assumes the pin model owns the timer input lines
`timescale 1ns/1ps
module testbench import tcpm_pkg::*;;
  // design stimulus and results
  logic        MCLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic        REG_WR_I, REG_RD_I, UPDATE_I, TRIG_EDGE_I, CNT_DOWN_I;
  logic [7:0]  REG_ADDR_I;
  logic [15:0] REG_WDATA_I, CNT_I, REG_RDATA_O;
  logic        FILTERED_EXTERNAL_TRIGGER_I, TIMER_INPUT_ONE_I, TIMER_INPUT_TWO_I;
  logic        INTERNAL_TRIGGER_CAPTURE_SRC_I;
  logic [1:0]  COMPARE_REFERENCE_O, MAIN_OUT_O, COMPLEMENTARY_OUT_O, CAPTURE_O;
  logic [15:0] cc0 = 16'h0, cc1 = 16'h0;
  int          error_cnt = 0, compares = 0;

  tcpm_top u_tcpm_top (
    .MCLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
    .CNT_I, .CNT_DOWN_I, .UPDATE_I, .TRIG_EDGE_I, .FILTERED_EXTERNAL_TRIGGER_I,
    .TIMER_INPUT_ONE_I, .TIMER_INPUT_TWO_I, .INTERNAL_TRIGGER_CAPTURE_SRC_I,
    .COMPARE_REFERENCE_O, .MAIN_OUT_O, .COMPLEMENTARY_OUT_O, .CAPTURE_O
  );
  tcpm_pins u_tcpm_pins (
    .mclk_i(MCLK_I), .ti_one_o(TIMER_INPUT_ONE_I), .ti_two_o(TIMER_INPUT_TWO_I),
    .etr_o(FILTERED_EXTERNAL_TRIGGER_I), .trc_o(INTERNAL_TRIGGER_CAPTURE_SRC_I)
  );

  // 200 MHz clock
  always #2.5 MCLK_I = ~MCLK_I;

  // count capture pulses per channel
  always @(posedge MCLK_I) begin
    if (CAPTURE_O[0] === 1'b1) cc0 <= cc0 + 16'h1;
    if (CAPTURE_O[1] === 1'b1) cc1 <= cc1 + 16'h1;
  end

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge MCLK_I);
    error_cnt++;
    results();
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    REG_WR_I    <= 1'b1;
    @(posedge MCLK_I);
    REG_WR_I <= 1'b0;
    @(posedge MCLK_I);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    REG_ADDR_I <= a;
    REG_RD_I   <= 1'b1;
    @(posedge MCLK_I);
    REG_RD_I <= 1'b0;
    @(negedge MCLK_I);
    chk("read data", e, REG_RDATA_O);
    @(posedge MCLK_I);
  endtask

  // one counter value, then reference of channel one
  task automatic cr(input logic [15:0] v, input logic e);
    CNT_I <= v;
    @(posedge MCLK_I);
    CNT_I <= 16'h0;
    @(negedge MCLK_I);
    chk("reference", 16'(e), 16'(COMPARE_REFERENCE_O[0]));
    @(posedge MCLK_I);
  endtask

  // set input mode, pulse a pin, count captures
  task automatic cap(input logic [15:0] m, en, input bit two, input int n, w,
                     input logic [15:0] e0, e1);
    logic [15:0] b0, b1;
    wr(CHAN_EN_OFS, 16'h0);
    wr(MODE_CTL_OFS, m);
    wr(CHAN_EN_OFS, en);
    b0 = cc0;
    b1 = cc1;
    u_tcpm_pins.pulses(two, n, w);
    repeat (6) @(posedge MCLK_I);
    chk("captures one", e0, cc0 - b0);
    chk("captures two", e1, cc1 - b1);
  endtask

  task automatic results();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {REG_WR_I, REG_RD_I, UPDATE_I, TRIG_EDGE_I, CNT_DOWN_I} = 5'h0;
    REG_ADDR_I  = 8'h0;
    REG_WDATA_I = 16'h0;
    CNT_I       = 16'h0;
    repeat (8) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge MCLK_I);
    rd(MODE_CTL_OFS, MODE_CTL_RST);
    rd(8'h10, 16'h0);
    wr(CMP1_OFS, 16'h5);
    wr(MODE_CTL_OFS, 16'h0010);
    cr(16'h5, 1'b1);
    wr(MODE_CTL_OFS, 16'h0028);
    wr(CMP1_OFS, 16'h9);
    cr(16'h9, 1'b1);
    rd(CMP1_OFS, 16'h9);
    UPDATE_I <= 1'b1;
    @(posedge MCLK_I);
    UPDATE_I <= 1'b0;
    cr(16'h9, 1'b0);
    wr(MODE_CTL_OFS, 16'h0030);
    cr(16'h9, 1'b1);
    cr(16'h9, 1'b0);
    wr(MODE_CTL_OFS, 16'h0050);
    cr(16'h1, 1'b1);
    wr(MODE_CTL_OFS, 16'h0000);
    cr(16'h9, 1'b1);
    wr(MODE_CTL_OFS, 16'h0040);
    cr(16'h9, 1'b0);
    wr(AUX_CTL_OFS, 16'h0004);
    wr(MODE_CTL_OFS, 16'h0060);
    cr(16'h3, 1'b1);
    cr(16'hc, 1'b0);
    CNT_DOWN_I <= 1'b1;
    cr(16'hc, 1'b1);
    CNT_DOWN_I <= 1'b0;
    wr(MODE_CTL_OFS, 16'h0070);
    cr(16'h3, 1'b0);
    cr(16'hc, 1'b1);
    // fast response: trigger edge forces pulse-width output
    CNT_I <= 16'hc;
    wr(MODE_CTL_OFS, 16'h0064);
    TRIG_EDGE_I <= 1'b1;
    @(posedge MCLK_I);
    TRIG_EDGE_I <= 1'b0;
    @(negedge MCLK_I);
    chk("fast early", 16'h0, 16'(COMPARE_REFERENCE_O[0]));
    repeat (3) @(posedge MCLK_I);
    @(negedge MCLK_I);
    chk("fast late", 16'h1, 16'(COMPARE_REFERENCE_O[0]));
    @(posedge MCLK_I);
    wr(MODE_CTL_OFS, 16'h00d0);
    u_tcpm_pins.set_etr(1'b1);
    cr(16'h1, 1'b0);
    wr(MODE_CTL_OFS, 16'h0050);
    cr(16'h1, 1'b1);
    u_tcpm_pins.set_etr(1'b0);
    wr(CHAN_EN_OFS, 16'h000a);
    @(negedge MCLK_I);
    chk("main out", 16'h0, 16'(MAIN_OUT_O[0]));
    chk("compl out", 16'h1, 16'(COMPLEMENTARY_OUT_O[0]));
    @(posedge MCLK_I);
    wr(AUX_CTL_OFS, 16'h0003);
    wr(MODE_CTL_OFS, 16'h0040);
    cr(16'h1, 1'b1);
    rd(MODE_CTL_OFS, 16'h0050);
    wr(AUX_CTL_OFS, 16'h0000);
    wr(CHAN_EN_OFS, 16'h0001);
    wr(MODE_CTL_OFS, 16'h0041);
    rd(MODE_CTL_OFS, 16'h0040);
    // every divider code over eight edges
    for (int p = 0; p < 4; p++) begin
      cap({12'h0, p[1:0], 2'h1}, 16'h1, 1'b0, 8, 2, 16'(8 >> p), 16'h0);
    end
    cap(16'h000d, 16'h1, 1'b0, 5, 2, 16'h0, 16'h0);
    cap(16'h000d, 16'h1, 1'b0, 3, 2, 16'h0, 16'h0);
    cap(16'h0011, 16'h1, 1'b0, 2, 1, 16'h0, 16'h0);
    cap(16'h0011, 16'h1, 1'b0, 2, 3, 16'h2, 16'h0);
    cap(16'h0102, 16'h0011, 1'b1, 3, 2, 16'h3, 16'h3);
    results();
  end
endmodule
